// ==== sxs_consts.svh ====
`ifndef SXS_CONSTS_SVH
`define SXS_CONSTS_SVH

// ==========================================================
// Operand widths and field positions.
`define SXS_DATA_W 8
`define SXS_ADDR_W 7
`define SXS_FILE_DEPTH 128
`define SXS_NIB_LO_MSB 3
`define SXS_NIB_HI_LSB 4

// ==========================================================
// Reset values.
`define SXS_ACC_RST 8'h00
`define SXS_FLAG_RST 1'b0

// ==========================================================
// Operation codes on the command port.
`define SXS_OP_SUB 2'h0
`define SXS_OP_XORL 2'h1
`define SXS_OP_XORF 2'h2
`define SXS_OP_SWAP 2'h3

// ==========================================================
// Destination bit values.
`define SXS_DEST_ACC 1'b0
`define SXS_DEST_FILE 1'b1

`endif

// ==== sxs_pkg.sv ====
`include "sxs_consts.svh"

package sxs_pkg;

   // Operation selector.
   typedef enum logic [1:0] {
      SXS_SUB = 2'b00,
      SXS_XORL = 2'b01,
      SXS_XORF = 2'b10,
      SXS_SWAP = 2'b11
   } sxs_op_t;

   // One decoded instruction from the decoder.
   typedef struct packed {
      sxs_op_t op;
      logic [`SXS_ADDR_W-1:0] addr;
      logic dest;
      logic [`SXS_DATA_W-1:0] lit;
   } sxs_cmd_t;

   // Status flags kept by the block.
   typedef struct packed {
      logic carry;
      logic digit_carry_flag;
      logic zero;
   } sxs_flags_t;

   // Execution sequencer states.
   typedef enum logic [1:0] {
      SXS_IDLE = 2'b00,
      SXS_READ = 2'b01,
      SXS_EXEC = 2'b10
   } sxs_state_t;

endpackage

// ==== sxs_file_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sxs_consts.svh"

// ==========================================================
// File register memory with a registered read port.
module sxs_file_mem (
   // Clock.
   input wire logic i_clk,
   // Write port.
   input wire logic i_we,
   input wire logic [`SXS_ADDR_W-1:0] i_waddr,
   input wire logic [`SXS_DATA_W-1:0] i_wdata,
   // Read port.
   input wire logic [`SXS_ADDR_W-1:0] i_raddr,
   output logic [`SXS_DATA_W-1:0] o_rdata
);

   logic [`SXS_DATA_W-1:0] mem_r [0:`SXS_FILE_DEPTH-1];

   // Stores a word when the write strobe is high.
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem_r[i_waddr] <= i_wdata;
      end
   end

   // Read data come out of a register one cycle after the address.
   always_ff @(posedge i_clk) begin
      o_rdata <= mem_r[i_raddr];
   end

endmodule
`default_nettype wire

// ==== sxs_alu.sv ====
// Function
// (RULE1) Subtract computes file minus accumulator, two's complement.
// (RULE2) Destination bit 0 accumulator, 1 file.
// (RULE3) Carry and digit carry set on no borrow.
// (RULE4) Literal XOR into accumulator, zero only.
// (RULE5) Swap exchanges nibbles, flags unchanged.
// (RULE6) File XOR to destination, zero only.
// (RULE7) Zero flag set when result is zero.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sxs_consts.svh"

// ==========================================================
// Accumulator datapath for subtract, XOR and nibble swap.
module sxs_alu (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Instruction command port.
   input wire logic i_cmd_valid,
   input wire sxs_pkg::sxs_cmd_t i_cmd,
   // Software register port.
   input wire logic [`SXS_ADDR_W-1:0] i_reg_addr,
   input wire logic [`SXS_DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [`SXS_DATA_W-1:0] o_reg_rdata,
   // Results and status.
   output logic o_busy,
   output logic o_done,
   output logic [`SXS_DATA_W-1:0] o_acc,
   output logic [`SXS_DATA_W-1:0] o_result,
   output sxs_pkg::sxs_flags_t o_flags
);
   import sxs_pkg::*;

   // ==========================================================
   // Helper functions.

   // Zero detect for an 8-bit result.
   function automatic logic is_zero(input logic [`SXS_DATA_W-1:0] v);
      is_zero = (v == 8'h00); // RULE7
   endfunction

   // Exchange the two nibbles of a byte.
   function automatic logic [`SXS_DATA_W-1:0] swap_nib(
      input logic [`SXS_DATA_W-1:0] v);
      swap_nib = {v[`SXS_NIB_LO_MSB:0],
                  v[`SXS_DATA_W-1:`SXS_NIB_HI_LSB]}; // RULE5
   endfunction

   // ==========================================================
   // State and storage.
   sxs_state_t state_r;
   sxs_cmd_t cmd_r;
   logic [`SXS_DATA_W-1:0] acc_r;
   sxs_flags_t flags_r;
   logic mem_we;
   logic [`SXS_ADDR_W-1:0] mem_waddr;
   logic [`SXS_ADDR_W-1:0] mem_raddr;
   logic [`SXS_DATA_W-1:0] mem_wdata;
   logic [`SXS_DATA_W-1:0] mem_rdata;
   logic [`SXS_ADDR_W-1:0] rd_addr_r;
   logic [`SXS_DATA_W:0] diff;
   logic [`SXS_NIB_HI_LSB:0] ndiff;
   logic [`SXS_DATA_W-1:0] res;
   logic exec;

   assign exec = (state_r == SXS_EXEC);

   // ==========================================================
   // Execution sequencer: take command, read operand, execute.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= SXS_IDLE;
      end else begin
         case (state_r)
            SXS_IDLE: begin
               if (i_cmd_valid) begin
                  state_r <= SXS_READ;
               end
            end
            SXS_READ: begin
               state_r <= SXS_EXEC;
            end
            SXS_EXEC: begin
               state_r <= SXS_IDLE;
            end
            default: begin
               state_r <= SXS_IDLE;
            end
         endcase
      end
   end

   // Captures the command when it is taken.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd_r <= '0;
      end else if (state_r == SXS_IDLE && i_cmd_valid) begin
         cmd_r <= i_cmd;
      end
   end

   // ==========================================================
   // Arithmetic on the file operand and the accumulator.
   always_comb begin
      diff = {1'b0, mem_rdata} - {1'b0, acc_r}; // RULE1
      ndiff = {1'b0, mem_rdata[`SXS_NIB_LO_MSB:0]}
            - {1'b0, acc_r[`SXS_NIB_LO_MSB:0]};
      case (cmd_r.op)
         SXS_SUB: res = diff[`SXS_DATA_W-1:0]; // RULE1
         SXS_XORL: res = acc_r ^ cmd_r.lit; // RULE4
         SXS_XORF: res = acc_r ^ mem_rdata; // RULE6
         SXS_SWAP: res = swap_nib(mem_rdata); // RULE5
         default: res = 8'h00;
      endcase
   end

   // ==========================================================
   // Accumulator update.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         acc_r <= `SXS_ACC_RST;
      end else if (exec) begin
         if (cmd_r.op == SXS_XORL) begin
            acc_r <= res; // RULE4
         end else if (cmd_r.dest == `SXS_DEST_ACC) begin
            acc_r <= res; // RULE2
         end
      end
   end

   // Status flag update.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flags_r <= '0;
      end else if (exec) begin
         case (cmd_r.op)
            SXS_SUB: begin
               flags_r.carry <= ~diff[`SXS_DATA_W]; // RULE3
               flags_r.digit_carry_flag <= ~ndiff[`SXS_NIB_HI_LSB]; // RULE3
               flags_r.zero <= is_zero(res); // RULE7
            end
            SXS_XORL, SXS_XORF: begin
               flags_r.zero <= is_zero(res); // RULE4 RULE6 RULE7
            end
            SXS_SWAP: begin
               flags_r <= flags_r; // RULE5
            end
            default: begin
               flags_r <= flags_r;
            end
         endcase
      end
   end

   // ==========================================================
   // File memory port steering: execution wins over software.
   always_comb begin
      if (state_r == SXS_READ) begin
         mem_raddr = cmd_r.addr;
      end else if (i_reg_rd) begin
         mem_raddr = i_reg_addr;
      end else begin
         mem_raddr = rd_addr_r;
      end
      if (exec && cmd_r.op != SXS_XORL &&
          cmd_r.dest == `SXS_DEST_FILE) begin
         mem_we = 1'b1; // RULE2
         mem_waddr = cmd_r.addr;
         mem_wdata = res;
      end else begin
         mem_we = i_reg_wr && (state_r == SXS_IDLE);
         mem_waddr = i_reg_addr;
         mem_wdata = i_reg_wdata;
      end
   end

   sxs_file_mem u_mem (
      .i_clk(i_clk),
      .i_we(mem_we),
      .i_waddr(mem_waddr),
      .i_wdata(mem_wdata),
      .i_raddr(mem_raddr),
      .o_rdata(mem_rdata)
   );

   // Holds the last software read address so its data keep standing.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_addr_r <= '0;
      end else if (i_reg_rd) begin
         rd_addr_r <= i_reg_addr;
      end
   end

   // Read data come straight from the memory's output register.
   // This gives the data in the cycle right after a read strobe outside SXS_READ; a strobe during SXS_READ gets them one cycle later.
   assign o_reg_rdata = mem_rdata;

   // ==========================================================
   // Registered outputs.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_result <= 8'h00;
      end else begin
         o_busy <= (state_r == SXS_IDLE) ? i_cmd_valid :
                   (state_r == SXS_READ);
         o_done <= exec;
         if (exec) begin
            o_result <= res;
         end
      end
   end

   // Copies of accumulator and flags, one cycle behind.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_acc <= `SXS_ACC_RST;
         o_flags <= '0;
      end else begin
         o_acc <= acc_r;
         o_flags <= flags_r;
      end
   end

endmodule
`default_nettype wire

// ==== sxs_alu_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sxs_consts.svh"
// ==========================================================
// Port checker for the accumulator datapath.
module sxs_alu_properties (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Command and results.
   input wire logic i_cmd_valid,
   input wire sxs_pkg::sxs_cmd_t i_cmd,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic [`SXS_DATA_W-1:0] o_acc,
   input wire logic [`SXS_DATA_W-1:0] o_result,
   input wire sxs_pkg::sxs_flags_t o_flags
);
   import sxs_pkg::*;
   sxs_cmd_t cmd_r, cmd_d_r;
   sxs_flags_t flg_r;
   logic dn_r;
   logic [7:0] acc_r, res_r, fv_r;
   // Marks the cycle after completion, when acc and flags turn new.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dn_r <= 1'b0;
      end else begin
         dn_r <= o_done;
      end
   end
   // Keeps the taken command, the one just finished, and the state
   // seen one cycle back, so a quickly following command is harmless.
   always_ff @(posedge i_clk) begin
      if (i_cmd_valid && !o_busy) begin
         cmd_r <= i_cmd;
      end
      if (o_done) begin
         cmd_d_r <= cmd_r;
      end
      acc_r <= o_acc;
      res_r <= o_result;
      fv_r <= o_result + o_acc;
      flg_r <= o_flags;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   AST_SUB_CARRY: assert property (o_done && cmd_r.op == SXS_SUB |=>
      o_flags.carry == (acc_r <= fv_r)) else $error("carry wrong");
   AST_SUB_DC: assert property (dn_r && cmd_d_r.op == SXS_SUB |->
      o_flags.digit_carry_flag == (acc_r[3:0] <= fv_r[3:0]))
      else $error("digit carry wrong");
   AST_DEST_ACC: assert property (dn_r && cmd_d_r.op != SXS_XORL &&
      !cmd_d_r.dest |-> o_acc == res_r) else $error("acc not written");
   AST_DEST_FILE: assert property (dn_r && cmd_d_r.op != SXS_XORL &&
      cmd_d_r.dest |-> o_acc == acc_r) else $error("acc overwritten");
   AST_XOR_LIT: assert property (dn_r && cmd_d_r.op == SXS_XORL |->
      o_acc == (acc_r ^ cmd_d_r.lit)) else $error("literal xor wrong");
   AST_SWAP_FLAGS: assert property (o_done && cmd_r.op == SXS_SWAP |=>
      $stable(o_flags)) else $error("swap touched flags");
   AST_XOR_FILE_FLAGS: assert property (dn_r && cmd_d_r.op == SXS_XORF |->
      o_flags[2:1] == flg_r[2:1]) else $error("file xor flags wrong");
   AST_ZERO: assert property (dn_r && cmd_d_r.op != SXS_SWAP |->
      o_flags.zero == (res_r == 8'h00)) else $error("zero flag wrong");
   // Main operations seen to complete.
   cover property (o_done && cmd_r.op == SXS_SUB);
   cover property (o_done && cmd_r.op == SXS_XORF);
   cover property (o_done && cmd_r.op == SXS_SWAP);
endmodule
`default_nettype wire

// ==== sxs_dec_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Instruction decoder model that feeds one command at a time.
module sxs_dec_model (
   // Clock.
   input wire logic i_clk,
   // Command to the datapath.
   output logic o_cmd_valid,
   output sxs_pkg::sxs_cmd_t o_cmd
);
   import sxs_pkg::*;
   // Idle lines carry a pattern that is never a held command.
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd = '1;
   end
   // One-cycle strobe, then the lines are scrambled.
   task automatic issue(input sxs_cmd_t c);
      @(posedge i_clk);
      o_cmd_valid <= 1'b1;
      o_cmd <= c;
      @(posedge i_clk);
      o_cmd_valid <= 1'b0;
      o_cmd <= ~c;
   endtask
endmodule
`default_nettype wire

// ==== tb_subtract_xor_swap_alu_ops.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench for the accumulator datapath.
module tb_subtract_xor_swap_alu_ops;
   import sxs_pkg::*;
   typedef struct packed {
      sxs_op_t op;
      logic [6:0] a;
      logic d;
      logic [7:0] k;
      logic [7:0] f;
      logic x;
   } sxs_row_t;
   logic i_clk, i_rst_n, i_cmd_valid, i_reg_wr, i_reg_rd, o_busy, o_done;
   sxs_cmd_t i_cmd;
   sxs_flags_t o_flags, ef;
   logic [6:0] i_reg_addr;
   logic [7:0] i_reg_wdata, o_reg_rdata, o_acc, o_result, ea, er;
   int errors, checks_done, cyc;
   sxs_row_t rows [10] = '{'{SXS_XORL, 7'h00, 1'b0, 8'h35, 8'h00, 1'b1},
      '{SXS_SUB, 7'h7f, 1'b0, 8'h00, 8'h35, 1'b0},
      '{SXS_XORL, 7'h00, 1'b1, 8'h5a, 8'h00, 1'b0},
      '{SXS_SUB, 7'h00, 1'b1, 8'h00, 8'h49, 1'b0},
      '{SXS_SUB, 7'h01, 1'b0, 8'h00, 8'h6b, 1'b0},
      '{SXS_XORF, 7'h02, 1'b1, 8'h00, 8'h11, 1'b0},
      '{SXS_SWAP, 7'h03, 1'b0, 8'h00, 8'h0f, 1'b0},
      '{SXS_SWAP, 7'h04, 1'b1, 8'h00, 8'hc3, 1'b0},
      '{SXS_XORF, 7'h05, 1'b0, 8'h00, 8'h0f, 1'b0},
      '{SXS_XORL, 7'h00, 1'b0, 8'hff, 8'h00, 1'b0}};
   sxs_dec_model u_dec (.i_clk, .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd));
   sxs_alu u_dut (.i_clk, .i_rst_n, .i_cmd_valid, .i_cmd, .i_reg_addr,
      .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_busy, .o_done,
      .o_acc, .o_result, .o_flags);
   // Clock of 100 ns period.
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Cuts a hang short.
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic check(input string n, input logic [7:0] s, e);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] v);
      @(posedge i_clk);
      i_reg_addr <= a;
      i_reg_wdata <= v;
      i_reg_wr <= 1'b1;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [6:0] a, output logic [7:0] v);
      @(posedge i_clk);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      @(posedge i_clk);
      v = o_reg_rdata;
   endtask
   // Preloads the operand, runs one command and compares all outcomes.
   task automatic run(input sxs_row_t r);
      logic [7:0] v;
      wr_reg(r.a, r.f);
      er = (r.op == SXS_SUB) ? r.f - ea : (r.op == SXS_XORL) ? ea ^ r.k :
         (r.op == SXS_XORF) ? ea ^ r.f : {r.f[3:0], r.f[7:4]};
      if (r.op == SXS_SUB) begin
         ef.carry = ea <= r.f;
         ef.digit_carry_flag = ea[3:0] <= r.f[3:0];
      end
      if (r.op != SXS_SWAP) ef.zero = er == 8'h00;
      if (r.op == SXS_XORL || !r.d) ea = er;
      u_dec.issue('{r.op, r.a, r.d, r.k});
      #1;
      check("busy", {7'h00, o_busy}, 8'h01);
      if (r.x) u_dec.issue('{SXS_XORL, 7'h00, 1'b0, ~r.k});
      #1;
      for (int i = 0; i < 8 && o_done !== 1'b1; i++) begin
         @(posedge i_clk);
         #1;
      end
      check("done", {7'h00, o_done}, 8'h01);
      check("idle", {7'h00, o_busy}, 8'h00);
      check("result", o_result, er);
      @(posedge i_clk);
      #1;
      check("acc", o_acc, ea);
      check("flags", {5'h00, o_flags}, {5'h00, ef});
      if (r.x) begin
         @(posedge i_clk);
         #1;
         check("refused", {7'h00, o_done}, 8'h00);
      end
      if (r.d && r.op != SXS_XORL) begin
         rd_reg(r.a, v);
         check("file", v, er);
      end
   endtask
   // Reset, reset values, then the table of commands.
   initial begin
      i_rst_n = 1'b0;
      i_reg_addr = '0;
      i_reg_wdata = '0;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      ea = 8'h00;
      ef = '0;
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      #1;
      check("acc", o_acc, 8'h00);
      check("flags", {5'h00, o_flags}, 8'h00);
      foreach (rows[j]) run(rows[j]);
      // Reset between commands clears accumulator and flags, then work resumes.
      run('{SXS_XORL, 7'h00, 1'b0, 8'ha5, 8'h00, 1'b0});
      i_rst_n <= 1'b0;
      #1;
      check("acc", o_acc, 8'h00);
      check("flags", {5'h00, o_flags}, 8'h00);
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      ea = 8'h00;
      ef = '0;
      run('{SXS_XORL, 7'h00, 1'b0, 8'h3c, 8'h00, 1'b0});
      report_and_stop();
   end
endmodule
bind sxs_alu sxs_alu_properties u_chk (.i_clk, .i_rst_n, .i_cmd_valid,
   .i_cmd, .o_busy, .o_done, .o_acc, .o_result, .o_flags);
`default_nettype wire
